// ---- src/nicdc_buf2.sv ----
`timescale 1ns/100ps
`default_nettype none
module nicdc_buf2
    import nicdc_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Fill side
    input  wire logic [DATA_W-1:0] s_data,
    input  wire logic              s_valid,
    output logic                   s_ready,
    // Drain side
    output logic [DATA_W-1:0]      m_data,
    output logic                   m_valid,
    input  wire logic              m_ready
);

    logic [DATA_W-1:0] mem_ff [BUF_DEPTH];
    logic [DATA_W-1:0] nxt_mem [BUF_DEPTH];
    logic              wr_ptr_ff, nxt_wr_ptr;
    logic              rd_ptr_ff, nxt_rd_ptr;
    logic [1:0]        count_ff,  nxt_count;
    logic              push, pop;

    // Honest full and empty flags
    assign s_ready = (count_ff != 2'h2);
    assign m_valid = (count_ff != 2'h0);
    assign m_data  = mem_ff[rd_ptr_ff];
    assign push    = s_valid && s_ready;
    assign pop     = m_valid && m_ready;

    // Pointer and storage update
    always_comb begin
        nxt_mem    = mem_ff;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_count  = count_ff;
        if (push) begin
            nxt_mem[wr_ptr_ff] = s_data;
            nxt_wr_ptr         = ~wr_ptr_ff;
        end
        if (pop) begin
            nxt_rd_ptr = ~rd_ptr_ff;
        end
        case ({push, pop})
            2'b10:   nxt_count = count_ff + 2'h1;
            2'b01:   nxt_count = count_ff - 2'h1;
            default: nxt_count = count_ff;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        mem_ff <= nxt_mem;
        if (rst) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff  <= 2'h0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff  <= nxt_count;
        end
    end

    a_buf_no_overflow : assert property (@(posedge sys_clk) disable iff (rst)
        (count_ff == 2'h2 && !pop) |=> count_ff == 2'h2)
        else $error("two-entry buffer count moved while full and stalled");

endmodule
`default_nettype wire

// ---- src/nicdc_cfg.sv ----
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module nicdc_cfg
    import nicdc_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    // DMA data from buffer RAM
    input  wire logic [DATA_W-1:0] dma_in_data,
    input  wire logic              dma_in_valid,
    output logic                   dma_in_ready,
    // DMA data toward the system data lanes
    output logic [DATA_W-1:0]      dma_out_data,
    output logic                   dma_out_valid,
    input  wire logic              dma_out_ready,
    // Remote DMA and command
    input  wire logic              send_cmd,
    output logic                   send_exec,
    output logic                   dma_single32,
    // FIFO thresholds
    input  wire logic [4:0]        rx_fifo_bytes,
    input  wire logic [4:0]        tx_fifo_bytes,
    output logic [4:0]             rx_threshold,
    output logic                   rx_flush_req,
    output logic                   tx_fetch_req,
    // Transmitter controls
    output logic                   crc_append,
    output logic [1:0]             loopback_mode,
    input  wire logic              mcast_hit,
    input  wire logic [5:0]        mcast_hash,
    output logic                   tx_enable,
    input  wire logic [4:0]        collision_num,
    output logic [4:0]             backoff_exp
);

    typedef enum logic [0:0] {FMT_FIRST, FMT_SECOND} nicdc_fmt_type;

    // Receive threshold decode, bytes are twice the words
    function automatic logic [4:0] thresh_bytes(input logic [1:0] code);
        case (code)
            2'h0:    thresh_bytes = 5'h02;
            2'h1:    thresh_bytes = 5'h04;
            2'h2:    thresh_bytes = 5'h08;
            default: thresh_bytes = 5'h0c;
        endcase
    endfunction

    logic [7:0]  dcfg_ff, nxt_dcfg;
    logic [7:0]  tcfg_ff, nxt_tcfg;
    logic        ack_ff,  nxt_ack;
    logic [31:0] rdat_ff, nxt_rdat;
    logic        bus_req, wr_dcfg, wr_tcfg;
    logic        txoff_ff, nxt_txoff;
    logic        send_ff, nxt_send;
    logic [4:0]  bexp_ff, nxt_bexp;
    logic [DATA_W-1:0] buf_data;
    logic        buf_valid, buf_ready;
    nicdc_fmt_type fmt_ff, nxt_fmt;
    logic [DATA_W-1:0] odat_ff, nxt_odat;
    logic        oval_ff, nxt_oval;
    logic        load_ok;

    // Bus request decode, answered one cycle later
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_dcfg = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == OFS_DATA_CFG);
    assign wr_tcfg = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == OFS_TX_CFG);

    // Register writes and bus answer
    always_comb begin
        nxt_ack  = bus_req;
        nxt_dcfg = dcfg_ff;
        nxt_tcfg = tcfg_ff;
        nxt_rdat = 32'h0;
        if (wr_dcfg) begin
            nxt_dcfg = wb_dat_i[7:0] & DCF_WR_MASK;
        end
        if (wr_tcfg) begin
            nxt_tcfg = wb_dat_i[7:0] & TCF_WR_MASK;
        end
        if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                OFS_DATA_CFG: nxt_rdat = {24'h0, dcfg_ff};
                OFS_TX_CFG:   nxt_rdat = {24'h0, tcfg_ff};
                OFS_STATUS:   nxt_rdat = {27'h0, fmt_ff == FMT_SECOND, oval_ff,
                                          buf_valid, txoff_ff, send_ff};
                default:      nxt_rdat = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dcfg_ff <= DCF_RESET;
            tcfg_ff <= TCF_RESET;
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0;
        end else begin
            dcfg_ff <= nxt_dcfg;
            tcfg_ff <= nxt_tcfg;
            ack_ff  <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    assign dma_single32 = dcfg_ff[DCF_LONG_ADDR];
    assign crc_append   = !tcfg_ff[TCF_INHIBIT_CRC];
    assign loopback_mode = dcfg_ff[DCF_LOOP_N] ? LB_NORMAL
                         : {tcfg_ff[TCF_LB_HI], tcfg_ff[TCF_LB_LO]};
    assign rx_threshold = thresh_bytes({dcfg_ff[DCF_FT_HI], dcfg_ff[DCF_FT_LO]});
    assign rx_flush_req = (rx_fifo_bytes >= rx_threshold);
    assign tx_fetch_req = (tx_fifo_bytes <= (FIFO_BYTES - rx_threshold));
    assign tx_enable    = !txoff_ff;
    assign send_exec    = send_ff;
    assign backoff_exp  = bexp_ff;

    // Transmitter gating, send command and backoff limit
    always_comb begin
        nxt_txoff = txoff_ff;
        if (!tcfg_ff[TCF_REMOTE_DIS]) begin
            nxt_txoff = 1'b0;
        end else if (mcast_hit && mcast_hash == HASH_TX_ON) begin
            nxt_txoff = 1'b0;
        end else if (mcast_hit && mcast_hash == HASH_TX_OFF) begin
            nxt_txoff = 1'b1;
        end
        nxt_send = send_cmd && dcfg_ff[DCF_AUTO_INIT];
        if (tcfg_ff[TCF_COLL_OFS] && collision_num != 5'h0
            && collision_num <= OFS_COLLISIONS) begin
            nxt_bexp = OFS_EXP_BASE + collision_num;
        end else begin
            nxt_bexp = collision_num;
        end
        if (nxt_bexp > BACKOFF_CAP) begin
            nxt_bexp = BACKOFF_CAP;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            txoff_ff <= 1'b0;
            send_ff  <= 1'b0;
            bexp_ff  <= 5'h0;
        end else begin
            txoff_ff <= nxt_txoff;
            send_ff  <= nxt_send;
            bexp_ff  <= nxt_bexp;
        end
    end

    // Two-entry buffer ahead of the lane formatter
    nicdc_buf2 u_buf (
        .sys_clk (sys_clk),
        .rst     (rst),
        .s_data  (dma_in_data),
        .s_valid (dma_in_valid),
        .s_ready (dma_in_ready),
        .m_data  (buf_data),
        .m_valid (buf_valid),
        .m_ready (buf_ready)
    );

    assign load_ok   = !oval_ff || dma_out_ready;
    assign buf_ready = load_ok && (dcfg_ff[DCF_WIDTH] || fmt_ff == FMT_SECOND);

    // Lane formatter: words, swapped words or split bytes
    always_comb begin
        nxt_fmt  = fmt_ff;
        nxt_odat = odat_ff;
        nxt_oval = oval_ff && !dma_out_ready;
        if (load_ok && buf_valid) begin
            nxt_oval = 1'b1;
            if (dcfg_ff[DCF_WIDTH]) begin
                nxt_fmt = FMT_FIRST;
                if (dcfg_ff[DCF_ORDER]) begin
                    nxt_odat = {buf_data[7:0], buf_data[15:8]};
                end else begin
                    nxt_odat = buf_data;
                end
            end else begin
                case (fmt_ff)
                    FMT_FIRST: begin
                        nxt_odat = {8'h0, buf_data[7:0]};
                        nxt_fmt  = FMT_SECOND;
                    end
                    FMT_SECOND: begin
                        nxt_odat = {8'h0, buf_data[15:8]};
                        nxt_fmt  = FMT_FIRST;
                    end
                    default: begin
                        nxt_fmt = FMT_FIRST;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fmt_ff  <= FMT_FIRST;
            odat_ff <= 16'h0;
            oval_ff <= 1'b0;
        end else begin
            fmt_ff  <= nxt_fmt;
            odat_ff <= nxt_odat;
            oval_ff <= nxt_oval;
        end
    end

    assign dma_out_data  = odat_ff;
    assign dma_out_valid = oval_ff;

    // Bus answers one cycle after request, then drops
    a_ack_follows_req : assert property (@(posedge sys_clk) disable iff (rst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not single cycle after request");

    a_reset_values : assert property (@(posedge sys_clk)
        rst |=> dcfg_ff[DCF_LONG_ADDR] && loopback_mode == LB_NORMAL)
        else $error("configuration reset values wrong");

    a_crc_inhibit : assert property (@(posedge sys_clk) disable iff (rst)
        (wr_tcfg && wb_dat_i[TCF_INHIBIT_CRC]) |=> !crc_append)
        else $error("CRC still appended after inhibit write");

    a_loop_normal : assert property (@(posedge sys_clk) disable iff (rst)
        (wr_dcfg && wb_dat_i[DCF_LOOP_N]) |=> loopback_mode == LB_NORMAL)
        else $error("loopback active with select high");

    a_send_gate : assert property (@(posedge sys_clk) disable iff (rst)
        send_exec |-> $past(send_cmd) && $past(dcfg_ff[DCF_AUTO_INIT]))
        else $error("send executed without auto-init");

    a_remote_off : assert property (@(posedge sys_clk) disable iff (rst)
        (tcfg_ff[TCF_REMOTE_DIS] && mcast_hit && mcast_hash == HASH_TX_OFF) |=> !tx_enable)
        else $error("transmitter not disabled by hash 62");

    a_remote_on : assert property (@(posedge sys_clk) disable iff (rst)
        (mcast_hit && mcast_hash == HASH_TX_ON) |=> tx_enable)
        else $error("transmitter not enabled by hash 63");

    a_backoff_ofs : assert property (@(posedge sys_clk) disable iff (rst)
        (tcfg_ff[TCF_COLL_OFS] && collision_num == 5'h2) |=> backoff_exp == 5'h5)
        else $error("offset backoff exponent wrong");

    a_thresholds : assert property (@(posedge sys_clk) disable iff (rst)
        (rx_threshold == 5'h0c && tx_fifo_bytes == 5'h05) |-> !tx_fetch_req)
        else $error("transmit refill threshold wrong");

    a_byte_lanes : assert property (@(posedge sys_clk) disable iff (rst)
        (dma_out_valid && !dcfg_ff[DCF_WIDTH] && fmt_ff == FMT_SECOND)
        |-> dma_out_data[15:8] == 8'h0)
        else $error("upper lanes driven in byte mode");

endmodule
`default_nettype wire

// ---- src/nicdc_pkg.sv ----
// How it works
// - Transfer width bit low gives byte-wide DMA, high gives word-wide DMA.
// - Byte order low keeps high byte on upper lanes; high swaps; byte mode ignores.
// - Long address bit picks dual 16-bit or single 32-bit mode; software clears it.
// - Long address bit comes out of reset set to one.
// - Loopback select is active low and also needs the loopback mode field programmed.
// - Auto-init bit set lets send command run; clear blocks it.
// - Threshold codes 0..3 mean 2, 4, 8, 12 bytes gathered before buffer write.
// - Transmit refill threshold is sixteen bytes minus the receive threshold.
// - Inhibit CRC bit low appends CRC, high omits it.
// - Loopback field selects normal, core, encoder/decoder or coax loopback.
// - Both loopback mode bits reset to zero.
// - Remote disable: hash 62 stops transmitter, hash 63 or clearing bit restarts it.
// - Collision offset limits first three backoffs to 2^min(3+n,10) slots.
package nicdc_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_DATA_CFG   = 8'h00;
    localparam logic [7:0] OFS_TX_CFG     = 8'h04;
    localparam logic [7:0] OFS_STATUS     = 8'h08;

    // Data configuration fields
    localparam int DCF_WIDTH      = 0;
    localparam int DCF_ORDER      = 1;
    localparam int DCF_LONG_ADDR  = 2;
    localparam int DCF_LOOP_N     = 3;
    localparam int DCF_AUTO_INIT  = 4;
    localparam int DCF_FT_LO      = 5;
    localparam int DCF_FT_HI      = 6;
    localparam logic [7:0] DCF_WR_MASK = 8'h7f;
    localparam logic [7:0] DCF_RESET   = 8'h04;

    // Transmit configuration fields
    localparam int TCF_INHIBIT_CRC = 0;
    localparam int TCF_LB_LO       = 1;
    localparam int TCF_LB_HI       = 2;
    localparam int TCF_REMOTE_DIS  = 3;
    localparam int TCF_COLL_OFS    = 4;
    localparam logic [7:0] TCF_WR_MASK = 8'h1f;
    localparam logic [7:0] TCF_RESET   = 8'h00;

    // Loopback modes
    localparam logic [1:0] LB_NORMAL     = 2'h0;
    localparam logic [1:0] LB_CORE       = 2'h1;
    localparam logic [1:0] LB_ENDEC      = 2'h2;
    localparam logic [1:0] LB_COAX       = 2'h3;

    // Remote disable hash bits
    localparam logic [5:0] HASH_TX_OFF   = 6'h3e;
    localparam logic [5:0] HASH_TX_ON    = 6'h3f;

    // FIFO and backoff figures
    localparam logic [4:0] FIFO_BYTES    = 5'h10;
    localparam logic [4:0] BACKOFF_CAP   = 5'h0a;
    localparam logic [4:0] OFS_COLLISIONS = 5'h03;
    localparam logic [4:0] OFS_EXP_BASE  = 5'h03;

    // Data path widths
    localparam int DATA_W = 16;
    localparam int BUF_DEPTH = 2;

endpackage

// ---- verif/nicdc_sink.sv ----
`timescale 1ns/100ps
`default_nettype none
module nicdc_sink
    import nicdc_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Stream from the block
    input  wire logic [DATA_W-1:0] dma_out_data,
    input  wire logic              dma_out_valid,
    output logic                   dma_out_ready,
    // Test control
    input  wire logic              stall
);
    logic [DATA_W-1:0] got[$];
    logic [1:0]        phase_ff;

    // Takes words; while stalling, ready only one cycle in four
    always @(posedge sys_clk) begin
        if (rst) begin
            phase_ff      <= 2'h0;
            dma_out_ready <= 1'b0;
        end else begin
            phase_ff      <= phase_ff + 2'h1;
            dma_out_ready <= !stall || (phase_ff == 2'h3);
            if (dma_out_valid && dma_out_ready) begin
                got.push_back(dma_out_data);
            end
        end
    end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench
    import nicdc_pkg::*;
;
    logic        sys_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack_o, stall, saw_full;
    logic [7:0]  wb_adr;
    logic [31:0] wb_dat, wb_dat_o, rd;
    logic [15:0] in_data, out_data;
    logic        in_valid, in_ready, out_valid, out_ready, send_cmd, send_exec;
    logic        dma_single32, rx_flush_req, tx_fetch_req, crc_append, mcast_hit, tx_enable;
    logic [4:0]  rx_fifo_bytes, tx_fifo_bytes, rx_threshold, collision_num, backoff_exp;
    logic [1:0]  loopback_mode;
    logic [5:0]  mcast_hash;
    int          n_fail, tests_run;

    nicdc_cfg dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dma_in_data(in_data),
        .dma_in_valid(in_valid), .dma_in_ready(in_ready), .dma_out_data(out_data),
        .dma_out_valid(out_valid), .dma_out_ready(out_ready), .send_cmd(send_cmd),
        .send_exec(send_exec), .dma_single32(dma_single32), .rx_fifo_bytes(rx_fifo_bytes),
        .tx_fifo_bytes(tx_fifo_bytes), .rx_threshold(rx_threshold),
        .rx_flush_req(rx_flush_req), .tx_fetch_req(tx_fetch_req), .crc_append(crc_append),
        .loopback_mode(loopback_mode), .mcast_hit(mcast_hit), .mcast_hash(mcast_hash),
        .tx_enable(tx_enable), .collision_num(collision_num), .backoff_exp(backoff_exp));

    nicdc_sink sink (.sys_clk(sys_clk), .rst(rst), .dma_out_data(out_data),
        .dma_out_valid(out_valid), .dma_out_ready(out_ready), .stall(stall));

    // Clock, 40 ns period
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One classic cycle; raised after an edge, released at the edge that samples ack high
    task automatic wb_io(input logic we, input logic [7:0] a, input logic [7:0] wd,
                         output logic [31:0] d);
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_dat <= {24'h000000, wd};
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1) @(posedge sys_clk);
        d = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic t_regs;
        wb_io(1'b0, OFS_DATA_CFG, 8'h00, rd);
        chk("dcfg_reset", rd, 32'h04);
        chk("single32_reset", dma_single32, 1'b1);
        wb_io(1'b0, OFS_TX_CFG, 8'h00, rd);
        chk("tcfg_reset", rd, 32'h00);
        chk("lb_reset", loopback_mode, LB_NORMAL);
        wb_io(1'b1, OFS_TX_CFG, 8'hdf, rd);
        wb_io(1'b0, OFS_TX_CFG, 8'h00, rd);
        chk("tcfg_reserved", rd, 32'h1f);
        wb_io(1'b1, OFS_DATA_CFG, 8'hf9, rd);
        wb_io(1'b0, OFS_DATA_CFG, 8'h00, rd);
        chk("dcfg_reserved", rd, 32'h79);
        wb_io(1'b1, OFS_DATA_CFG, 8'h08, rd);
        chk("single32_clear", dma_single32, 1'b0);
        wb_io(1'b1, 8'h0c, 8'h55, rd);
        wb_io(1'b0, 8'h0c, 8'h00, rd);
        chk("unmapped", rd, 32'h0);
    endtask

    task automatic t_loop;
        wb_io(1'b1, OFS_DATA_CFG, 8'h00, rd);
        for (int m = 0; m < 4; m++) begin
            wb_io(1'b1, OFS_TX_CFG, {5'h00, m[1:0], m[0]}, rd);
            @(negedge sys_clk);
            chk("lb_mode", loopback_mode, m[1:0]);
            chk("crc_append", crc_append, !m[0]);
        end
        wb_io(1'b1, OFS_DATA_CFG, 8'h08, rd);
        @(negedge sys_clk);
        chk("lb_gated", loopback_mode, LB_NORMAL);
    endtask

    task automatic t_thresh;
        logic [4:0] th;
        for (int c = 0; c < 4; c++) begin
            th = (c == 0) ? 5'h02 : (c == 1) ? 5'h04 : (c == 2) ? 5'h08 : 5'h0c;
            wb_io(1'b1, OFS_DATA_CFG, {1'b0, c[1:0], 5'h08}, rd);
            rx_fifo_bytes <= th - 5'h01;
            tx_fifo_bytes <= FIFO_BYTES - th;
            @(negedge sys_clk);
            chk("rx_thr", rx_threshold, th);
            chk("flush_lo", rx_flush_req, 1'b0);
            chk("fetch_hi", tx_fetch_req, 1'b1);
            @(posedge sys_clk);
            rx_fifo_bytes <= th;
            tx_fifo_bytes <= FIFO_BYTES - th + 5'h01;
            @(negedge sys_clk);
            chk("flush_hi", rx_flush_req, 1'b1);
            chk("fetch_lo", tx_fetch_req, 1'b0);
        end
    endtask

    task automatic t_send(input logic ai);
        wb_io(1'b1, OFS_DATA_CFG, {3'h0, ai, 4'h8}, rd);
        send_cmd <= 1'b1;
        @(posedge sys_clk);
        send_cmd <= 1'b0;
        @(negedge sys_clk);
        chk("send_exec", send_exec, ai);
        @(negedge sys_clk);
        chk("send_exec_end", send_exec, 1'b0);
    endtask

    task automatic hit(input logic [5:0] h);
        @(posedge sys_clk);
        mcast_hash <= h;
        mcast_hit  <= 1'b1;
        @(posedge sys_clk);
        mcast_hit  <= 1'b0;
        mcast_hash <= ~h;
        @(negedge sys_clk);
    endtask

    task automatic t_remote;
        wb_io(1'b1, OFS_TX_CFG, 8'h08, rd);
        hit(HASH_TX_OFF);
        chk("tx_off", tx_enable, 1'b0);
        wb_io(1'b0, OFS_STATUS, 8'h00, rd);
        chk("status_tx_off", rd, 32'h02);
        hit(HASH_TX_ON);
        chk("tx_on", tx_enable, 1'b1);
        hit(HASH_TX_OFF);
        wb_io(1'b1, OFS_TX_CFG, 8'h00, rd);
        @(negedge sys_clk);
        chk("tx_on_clear", tx_enable, 1'b1);
        hit(HASH_TX_OFF);
        chk("tx_ignored", tx_enable, 1'b1);
    endtask

    task automatic t_backoff;
        logic [4:0] e;
        for (int o = 0; o < 2; o++) begin
            wb_io(1'b1, OFS_TX_CFG, {3'h0, o[0], 4'h0}, rd);
            for (int n = 0; n < 13; n++) begin
                e = (n > 10) ? 5'h0a : n[4:0];
                if (o == 1 && n >= 1 && n <= 3) e = n[4:0] + 5'h03;
                @(posedge sys_clk);
                collision_num <= n[4:0];
                @(negedge sys_clk);
                @(negedge sys_clk);
                chk("backoff_exp", backoff_exp, e);
            end
        end
    endtask

    task automatic t_stream(input logic [7:0] cfg, input logic stl);
        logic [15:0] w;
        logic [15:0] exp[$];
        wb_io(1'b1, OFS_DATA_CFG, cfg, rd);
        stall <= stl;
        saw_full = 1'b0;
        sink.got.delete();
        for (int i = 0; i < 6; i++) begin
            w = 16'ha1b2 + 16'h1111 * i[15:0];
            if (cfg[DCF_WIDTH]) exp.push_back(cfg[DCF_ORDER] ? {w[7:0], w[15:8]} : w);
            else begin
                exp.push_back({8'h00, w[7:0]});
                exp.push_back({8'h00, w[15:8]});
            end
            in_valid <= 1'b1;
            in_data  <= w;
            @(negedge sys_clk);
            while (in_ready !== 1'b1) begin
                saw_full = 1'b1;
                @(negedge sys_clk);
            end
            @(posedge sys_clk);
        end
        in_valid <= 1'b0;
        in_data  <= ~w;
        for (int k = 0; k < 300 && sink.got.size() < exp.size(); k++) @(negedge sys_clk);
        chk("beats", sink.got.size(), exp.size());
        for (int i = 0; i < exp.size() && i < sink.got.size(); i++)
            chk("beat_data", sink.got[i], exp[i]);
        if (stl) chk("refused_when_full", saw_full, 1'b1);
        stall <= 1'b0;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        finish_test();
    end

    // Main sequence
    initial begin
        {rst, stall, wb_cyc, wb_stb, wb_we, in_valid, send_cmd, mcast_hit} = 8'h80;
        {wb_adr, wb_dat, in_data, mcast_hash} = '0;
        {rx_fifo_bytes, tx_fifo_bytes, collision_num} = '0;
        n_fail = 0;
        tests_run = 0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk("tx_en_reset", tx_enable, 1'b1);
        chk("crc_reset", crc_append, 1'b1);
        t_regs();
        t_loop();
        t_thresh();
        t_send(1'b1);
        t_send(1'b0);
        t_remote();
        t_backoff();
        t_stream(8'h09, 1'b0);
        t_stream(8'h0b, 1'b1);
        t_stream(8'h08, 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
